// *** rtl/uart_channel_mode_flow_ctrl.sv ***
// Purpose: one serial channel with channel modes, auto RTS, CTS gating, stop length
// Assumes: classic single-cycle bus master, inputs synchronous to sys_clk_i
// Notes: bit timing from a 16x tick shared by receiver and transmitter
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "uart_chan_params.svh"
module uart_channel_mode_flow_ctrl import uart_chan_pkg::*; #(
  parameter int BAUD_DIV = 8,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // register bus
  input wire wb_req_t wb_i,
  output wb_rsp_t wb_o,
  // serial line
  input wire logic serial_rx_in_i,
  output logic serial_tx_out_o,
  // modem control
  input wire logic clear_to_send_in_n_i,
  output logic request_to_send_out_n_o
);
  chan_state_t st_q;
  chan_state_t d;
  logic tick;
  logic wr;
  logic echo_m;
  logic echo_now;
  logic auto_rts;
  logic rx_in;
  logic [2:0] last_bit;
  logic [7:0] rx_word;
  logic [7:0] status;
  logic fifo_push;
  logic fifo_pop;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;

  function automatic logic is_echo(input logic [7:0] m);
    is_echo = (m[`MODE_CHAN_HI:`MODE_CHAN_LO] == AUTO_ECHO) ||
              (m[`MODE_CHAN_HI:`MODE_CHAN_LO] == REMOTE_LOOP);
  endfunction : is_echo

  // stop length in 16x ticks
  function automatic logic [5:0] stop_ticks(input logic [3:0] code, input logic [1:0] clen,
                                            input logic ext1x);
    logic [5:0] t;
    t = code[3] ? `STOP_LONG_BASE : `STOP_SHORT_BASE;
    t = t + {3'h0, code[2:0]};
    if (!code[3] && clen == 2'h0) begin
      t = t + `STOP_5BIT_ADD;
    end
    if (ext1x) begin
      t = code[3] ? (`TICKS_PER_BIT << 1) : `TICKS_PER_BIT;
    end
    stop_ticks = t;
  endfunction : stop_ticks

  function automatic logic mode_is(input logic [7:0] m, input chan_mode_t c);
    mode_is = (m[`MODE_CHAN_HI:`MODE_CHAN_LO] == c);
  endfunction : mode_is

  chan_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(wb_i.dat[7:0]),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );

  assign serial_tx_out_o = st_q.tx_pin;
  assign request_to_send_out_n_o = ~st_q.ctrl[`CTRL_OPR];
  assign wb_o.ack = st_q.ack;
  assign wb_o.dat = st_q.rdat;

  always_comb begin
    d = st_q;
    fifo_push = 1'b0;
    fifo_pop = 1'b0;
    tick = (st_q.div == 8'(BAUD_DIV - 1));
    d.div = tick ? 8'h00 : st_q.div + 8'h01;
    echo_m = is_echo(st_q.mode);
    echo_now = echo_m || (st_q.echo_hold != 5'h00);
    last_bit = {1'b0, st_q.ctrl[`CTRL_LEN_LO+1:`CTRL_LEN_LO]} + 3'h4;
    auto_rts = st_q.mode[`MODE_RTS_AUTO] && !st_q.ctrl[`CTRL_TX_EN] &&
               st_q.ctrl[`CTRL_OPR] && !fifo_out_valid;
    rx_in = mode_is(st_q.mode, LOCAL_LOOP) ? st_q.tx_line : serial_rx_in_i;
    rx_word = st_q.rx_sh >> (2'h3 - st_q.ctrl[`CTRL_LEN_LO+1:`CTRL_LEN_LO]);
    wr = wb_i.we && wb_i.sel[0];
    status = '0;
    status[0] = fifo_in_ready && !echo_m;
    status[1] = !fifo_out_valid && (st_q.tx_st == TX_IDLE) && !echo_m;
    status[2] = st_q.rx_rdy;
    status[3] = st_q.pe && !mode_is(st_q.mode, REMOTE_LOOP);
    status[4] = st_q.fe && !mode_is(st_q.mode, REMOTE_LOOP);
    status[5] = st_q.brk && !mode_is(st_q.mode, REMOTE_LOOP);
    status[6] = st_q.ctrl[`CTRL_OPR];

    // transmitter, runs on its own in normal mode
    if (tick) begin
      d.tx_cnt = st_q.tx_cnt + 6'h01;
      case (st_q.tx_st)
        TX_IDLE: begin
          d.tx_cnt = '0;
          // CTS is looked at only here, between characters
          if (!echo_now && fifo_out_valid &&
              !(st_q.mode[`MODE_CTS_EN] && clear_to_send_in_n_i)) begin
            fifo_pop = 1'b1;
            d.tx_sh = fifo_out_data;
            d.tx_line = 1'b0;
            d.tx_par = st_q.ctrl[`CTRL_PAR_ODD];
            d.tx_st = TX_START;
          end else if (auto_rts) begin
            d.tx_st = TX_RTS;
          end
        end
        TX_START: begin
          if (st_q.tx_cnt == `TICKS_PER_BIT - 6'h01) begin
            d.tx_cnt = '0;
            d.tx_bit = '0;
            d.tx_line = st_q.tx_sh[0];
            d.tx_par = st_q.tx_par ^ st_q.tx_sh[0];
            d.tx_st = TX_DATA;
          end
        end
        TX_DATA: begin
          if (st_q.tx_cnt == `TICKS_PER_BIT - 6'h01) begin
            d.tx_cnt = '0;
            if (st_q.tx_bit == last_bit) begin
              d.tx_line = st_q.ctrl[`CTRL_PAR_EN] ? st_q.tx_par : 1'b1;
              d.tx_st = st_q.ctrl[`CTRL_PAR_EN] ? TX_PAR : TX_STOP;
            end else begin
              d.tx_bit = st_q.tx_bit + 3'h1;
              d.tx_sh = st_q.tx_sh >> 1;
              d.tx_line = st_q.tx_sh[1];
              d.tx_par = st_q.tx_par ^ st_q.tx_sh[1];
            end
          end
        end
        TX_PAR: begin
          if (st_q.tx_cnt == `TICKS_PER_BIT - 6'h01) begin
            d.tx_cnt = '0;
            d.tx_line = 1'b1;
            d.tx_st = TX_STOP;
          end
        end
        TX_STOP: begin
          if (st_q.tx_cnt == stop_ticks(st_q.mode[`MODE_STOP_HI:0],
                                        st_q.ctrl[`CTRL_LEN_LO+1:`CTRL_LEN_LO],
                                        st_q.ctrl[`CTRL_EXT1X]) - 6'h01) begin
            d.tx_cnt = '0;
            d.tx_st = TX_IDLE;
          end
        end
        TX_RTS: begin
          // one bit time of idle line after the last stop bit
          if (!auto_rts) begin
            d.tx_st = TX_IDLE;
          end else if (st_q.tx_cnt == `TICKS_PER_BIT - 6'h01) begin
            d.ctrl[`CTRL_OPR] = 1'b0;
            d.tx_st = TX_IDLE;
          end
        end
        default: begin
          d.tx_st = TX_IDLE;
        end
      endcase
    end

    // register bus, single-cycle ack except on a full transmit FIFO
    d.ack = 1'b0;
    if (wb_i.cyc && wb_i.stb && !st_q.ack) begin
      d.ack = 1'b1;
      d.rdat = '0;
      case (wb_i.adr)
        `REG_MODE_TWO: begin
          d.rdat = {24'h0, st_q.mode};
          if (wr) begin
            d.mode = wb_i.dat[7:0];
          end
        end
        `REG_CTRL: begin
          d.rdat = {24'h0, st_q.ctrl};
          if (wr) begin
            d.ctrl = wb_i.dat[7:0];
          end
        end
        `REG_TXDATA: begin
          if (wr && st_q.ctrl[`CTRL_TX_EN]) begin
            d.ack = fifo_in_ready;
            fifo_push = fifo_in_ready;
          end
        end
        `REG_RXDATA: begin
          d.rdat = {24'h0, st_q.rx_data};
          if (!wb_i.we) begin
            d.rx_rdy = 1'b0;
            d.fe = 1'b0;
            d.pe = 1'b0;
            d.brk = 1'b0;
          end
        end
        `REG_STATUS: begin
          d.rdat = {24'h0, status};
        end
        default: begin
          d.rdat = '0;
        end
      endcase
    end

    // receiver and echo path, after the bus so a new character beats a read clear
    if (tick) begin
      d.rx_prev = rx_in;
      d.echo_line = rx_in;
      if (st_q.echo_hold != 5'h00) begin
        d.echo_hold = st_q.echo_hold - 5'h01;
      end
      d.rx_cnt = st_q.rx_cnt + 6'h01;
      case (st_q.rx_st)
        RX_IDLE: begin
          d.rx_cnt = '0;
          // edge, not level, so a held break does not restart the receiver
          if (st_q.rx_prev && !rx_in) begin
            d.rx_st = RX_START;
          end
        end
        RX_START: begin
          if (st_q.rx_cnt == `HALF_BIT - 6'h01) begin
            d.rx_cnt = '0;
            d.rx_bit = '0;
            d.rx_par = 1'b0;
            d.rx_st = rx_in ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (st_q.rx_cnt == `TICKS_PER_BIT - 6'h01) begin
            d.rx_cnt = '0;
            d.rx_sh = {rx_in, st_q.rx_sh[7:1]};
            d.rx_par = st_q.rx_par ^ rx_in;
            d.rx_bit = st_q.rx_bit + 3'h1;
            if (st_q.rx_bit == last_bit) begin
              d.rx_st = st_q.ctrl[`CTRL_PAR_EN] ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (st_q.rx_cnt == `TICKS_PER_BIT - 6'h01) begin
            d.rx_cnt = '0;
            d.rx_par = st_q.rx_par ^ rx_in;
            d.rx_st = RX_STOP;
          end
        end
        RX_STOP: begin
          if (st_q.rx_cnt == `TICKS_PER_BIT - 6'h01) begin
            d.rx_cnt = '0;
            d.rx_st = RX_IDLE;
            if (echo_m && st_q.ctrl[`CTRL_TX_EN]) begin
              d.echo_hold = `ECHO_HOLD_TICKS;
            end
            if (st_q.ctrl[`CTRL_RX_EN] && !mode_is(st_q.mode, REMOTE_LOOP)) begin
              d.rx_data = rx_word;
              d.rx_rdy = 1'b1;
              d.fe = !rx_in;
              d.pe = st_q.ctrl[`CTRL_PAR_EN] &&
                     (st_q.rx_par != st_q.ctrl[`CTRL_PAR_ODD]);
              d.brk = (rx_word == 8'h00) && !rx_in;
            end
          end
        end
        default: begin
          d.rx_st = RX_IDLE;
        end
      endcase
    end

    // pin: echoed line, held mark in local loop, else own transmitter
    if (echo_now) begin
      d.tx_pin = st_q.echo_line;
    end else if (mode_is(st_q.mode, LOCAL_LOOP)) begin
      d.tx_pin = 1'b1;
    end else begin
      d.tx_pin = st_q.tx_line;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= CHAN_RST;
    end else begin
      st_q <= d;
    end
  end
endmodule : uart_channel_mode_flow_ctrl

// *** rtl/uart_chan_params.svh ***
// Purpose: register offsets, field positions, reset values and bit timing
// Assumes: 32-bit classic bus, one register per aligned word
// Notes: offsets are byte addresses
`ifndef UART_CHAN_PARAMS_SVH
`define UART_CHAN_PARAMS_SVH
`define REG_MODE_TWO 5'h00
`define REG_CTRL 5'h04
`define REG_TXDATA 5'h08
`define REG_RXDATA 5'h0C
`define REG_STATUS 5'h10
`define MODE_RST 8'h00
`define CTRL_RST 8'h00
`define MODE_CHAN_HI 7
`define MODE_CHAN_LO 6
`define MODE_RTS_AUTO 5
`define MODE_CTS_EN 4
`define MODE_STOP_HI 3
`define CTRL_TX_EN 0
`define CTRL_RX_EN 1
`define CTRL_OPR 2
`define CTRL_LEN_LO 3
`define CTRL_PAR_EN 5
`define CTRL_PAR_ODD 6
`define CTRL_EXT1X 7
`define TICKS_PER_BIT 6'd16
`define HALF_BIT 6'd8
`define STOP_SHORT_BASE 6'd9
`define STOP_LONG_BASE 6'd25
`define STOP_5BIT_ADD 6'd8
`define ECHO_HOLD_TICKS 5'd16
`define FIFO_DEPTH 16
`endif

// *** rtl/uart_chan_pkg.sv ***
// Purpose: types shared by the channel and its test bench
// Assumes: uart_chan_params.svh on the include path
// Notes: none
package uart_chan_pkg;
  `include "uart_chan_params.svh"
  typedef enum logic [1:0] {
    NORMAL = 2'h0, AUTO_ECHO = 2'h1, LOCAL_LOOP = 2'h2, REMOTE_LOOP = 2'h3
  } chan_mode_t;
  typedef enum logic [5:0] {
    TX_IDLE = 6'h01, TX_START = 6'h02, TX_DATA = 6'h04,
    TX_PAR = 6'h08, TX_STOP = 6'h10, TX_RTS = 6'h20
  } tx_state_t;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
  } rx_state_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [4:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] ctrl;
    logic ack;
    logic [31:0] rdat;
    logic [7:0] div;
    tx_state_t tx_st;
    logic [5:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_par;
    logic tx_line;
    logic tx_pin;
    rx_state_t rx_st;
    logic [5:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_par;
    logic rx_prev;
    logic [7:0] rx_data;
    logic rx_rdy;
    logic fe;
    logic pe;
    logic brk;
    logic echo_line;
    logic [4:0] echo_hold;
  } chan_state_t;
  localparam chan_state_t CHAN_RST = '{
    mode: `MODE_RST, ctrl: `CTRL_RST, tx_st: TX_IDLE, rx_st: RX_IDLE,
    tx_line: 1'b1, tx_pin: 1'b1, rx_prev: 1'b1, echo_line: 1'b1, default: '0};
endpackage : uart_chan_pkg

// *** rtl/chan_fifo.sv ***
// Purpose: flip-flop FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: out_data is valid whenever out_valid is high
`timescale 1ns/10ps
module chan_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_state_t;
  fifo_state_t st_q;
  fifo_state_t st_d;
  logic push;
  logic pop;

  assign in_ready_o = (st_q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (st_q.cnt != '0);
  assign out_data_o = st_q.mem[st_q.rd];

  always_comb begin
    st_d = st_q;
    push = in_valid_i && in_ready_o;
    pop = out_ready_i && out_valid_o;
    if (push) begin
      st_d.mem[st_q.wr] = in_data_i;
      st_d.wr = st_q.wr + 1'b1;
    end
    if (pop) begin
      st_d.rd = st_q.rd + 1'b1;
    end
    if (push && !pop) begin
      st_d.cnt = st_q.cnt + 1'b1;
    end else if (pop && !push) begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule : chan_fifo

// *** verif/chan_checker_asserts.sv ***
// Purpose: port-level checks for the channel block
// Assumes: mode and control shadowed from acknowledged bus writes
// Notes: bound into every instance of the channel
`timescale 1ns/10ps
`include "uart_chan_params.svh"
module chan_checker import uart_chan_pkg::*; #(
  parameter int BAUD_DIV = 8
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // register bus
  input wire wb_req_t wb_i,
  input wire wb_rsp_t wb_o,
  // line and modem pins
  input wire logic serial_rx_in_i,
  input wire logic serial_tx_out_o,
  input wire logic clear_to_send_in_n_i,
  input wire logic request_to_send_out_n_o
);
  logic [7:0] mode_q;
  logic [7:0] ctrl_q;
  logic [11:0] mcnt_q;
  logic [11:0] idle_q;
  logic wr_ack;
  logic rd_ack;
  assign wr_ack = wb_o.ack && wb_i.we && wb_i.sel[0];
  assign rd_ack = wb_o.ack && !wb_i.we;
  // cycles since a mode or control write, and cycles the tx pin has been marking
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_q <= 8'h00;
      ctrl_q <= 8'h00;
      mcnt_q <= 12'h000;
      idle_q <= 12'h000;
    end else begin
      if (wr_ack && wb_i.adr == `REG_MODE_TWO) mode_q <= wb_i.dat[7:0];
      if (wr_ack && wb_i.adr == `REG_CTRL) ctrl_q <= wb_i.dat[7:0];
      mcnt_q <= (wr_ack && wb_i.adr <= `REG_CTRL) ? 12'h000 : mcnt_q + 12'(mcnt_q != 12'hFFF);
      idle_q <= !serial_tx_out_o ? 12'h000 : idle_q + 12'(idle_q != 12'hFFF);
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  a_ack_pulse: assert property (wb_o.ack |=> !wb_o.ack) else $error("ack held too long");
  a_ack_cause: assert property (wb_o.ack |-> $past(wb_i.cyc && wb_i.stb))
    else $error("ack without request");
  a_rd_hi_zero: assert property (rd_ack |-> wb_o.dat[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_rd_empty: assert property (rd_ack && (wb_i.adr == `REG_TXDATA || wb_i.adr > `REG_STATUS)
    |-> wb_o.dat == 32'h00000000) else $error("empty place read nonzero");
  a_mode_read: assert property (rd_ack && wb_i.adr == `REG_MODE_TWO
    |-> wb_o.dat[7:0] == mode_q) else $error("mode readback differs");
  a_local_high: assert property (mode_q[7:6] == 2'b10 && mcnt_q > 12'(40 * BAUD_DIV)
    |-> serial_tx_out_o) else $error("tx pin low in local loop");
  a_echo_copy: assert property ((mode_q[6] && ctrl_q[1] && mcnt_q > 12'(40 * BAUD_DIV)
    && $stable(serial_rx_in_i)) [*5] |-> serial_tx_out_o == serial_rx_in_i)
    else $error("echo does not follow rx");
  a_rts_write: assert property (wr_ack && wb_i.adr == `REG_CTRL && !mode_q[5]
    |=> ##1 request_to_send_out_n_o == !ctrl_q[2]) else $error("rts pin not from control");
  a_rts_auto: assert property (mode_q[7:5] == 3'b001 && !ctrl_q[0]
    && mcnt_q > 12'(300 * BAUD_DIV) && (!mode_q[4] || !clear_to_send_in_n_i)
    && idle_q > 12'(300 * BAUD_DIV)
    |-> request_to_send_out_n_o) else $error("rts not dropped after drain");
  a_cts_hold: assert property ((mode_q[7:6] == 2'b00 && mode_q[4]
    && clear_to_send_in_n_i && idle_q > 12'(200 * BAUD_DIV)) [*4] |=> serial_tx_out_o)
    else $error("start while cts high");
  c_echo: cover property (mode_q[7:6] == 2'b01 && !serial_tx_out_o);
  c_rts_drop: cover property (mode_q[5] && $rose(request_to_send_out_n_o));
  c_cts_wait: cover property (mode_q[4] && clear_to_send_in_n_i && idle_q > 12'(200 * BAUD_DIV));
endmodule : chan_checker
bind uart_channel_mode_flow_ctrl chan_checker #(.BAUD_DIV(BAUD_DIV)) u_chk (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .wb_i(wb_i), .wb_o(wb_o),
  .serial_rx_in_i(serial_rx_in_i), .serial_tx_out_o(serial_tx_out_o),
  .clear_to_send_in_n_i(clear_to_send_in_n_i), .request_to_send_out_n_o(request_to_send_out_n_o));

// *** verif/remote_serial_dev.sv ***
// Purpose: far end of the serial line, sends and collects 8N1 frames
// Assumes: one bit lasts BIT_CLKS system clocks
// Notes: collected bytes queue up in got
`timescale 1ns/10ps
module remote_serial_dev #(
  parameter int BIT_CLKS = 16
) (
  // clock
  input wire logic clk_i,
  // line into the channel receiver, marking when idle
  output logic line_o,
  // line from the channel transmitter
  input wire logic line_i
);
  logic [7:0] got [$];
  initial line_o = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      line_o <= f[i];
      repeat (BIT_CLKS - 1) @(posedge clk_i);
    end
  endtask : send
  // samples each bit at its centre, keeps the byte only with a valid stop
  always begin : rx_side
    logic [7:0] s;
    @(negedge line_i);
    repeat (BIT_CLKS / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk_i);
      s[i] = line_i;
    end
    repeat (BIT_CLKS) @(posedge clk_i);
    if (line_i === 1'b1) got.push_back(s);
  end
endmodule : remote_serial_dev

// *** verif/uart_channel_mode_flow_ctrl_tb.sv ***
// Purpose: self-checking bench for the channel mode and flow control block
// Assumes: BAUD_DIV of 1, so one bit is 16 clocks
// Notes: remote_serial_dev plays the far end of the line
`timescale 1ns/10ps
`include "uart_chan_params.svh"
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin err_total++; \
  $display("unexpected %s exp %0h got %0h", nm, e, a); end end
module uart_channel_mode_flow_ctrl_tb import uart_chan_pkg::*; ;
  localparam logic [7:0] ST_CTRL [8] = '{8'h03, 8'h03, 8'h1B, 8'h1B, 8'h1B, 8'h1B, 8'h9B, 8'h9B};
  localparam logic [7:0] ST_MODE [8] = '{8'h00, 8'h08, 8'h00, 8'h07, 8'h08, 8'h0F, 8'h00, 8'h08};
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  wb_req_t req = '0;
  wb_rsp_t rsp;
  logic rx_line, tx_line, rts_n;
  logic cts_n = 1'b0;
  logic [7:0] r, b, c;
  logic [7:0] q [$];
  int err_total = 0;
  int compares = 0;
  int cyc_n = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  uart_channel_mode_flow_ctrl #(.BAUD_DIV(1), .FIFO_DEPTH(16)) uut (.sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i), .wb_i(req), .wb_o(rsp), .serial_rx_in_i(rx_line),
    .serial_tx_out_o(tx_line), .clear_to_send_in_n_i(cts_n), .request_to_send_out_n_o(rts_n));
  remote_serial_dev dev (.clk_i(sys_clk_i), .line_o(rx_line), .line_i(tx_line));
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  always @(posedge sys_clk_i) begin
    cyc_n++;
    if (cyc_n == 60000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h1, dat: {24'h000000, d}};
    // ack is looked at on the rising edge only; the request stands until then
    do @(posedge sys_clk_i); while (rsp.ack !== 1'b1);
    r = rsp.dat[7:0];
    req <= '0;
  endtask : bus
  task automatic poll_st(input int bi);
    do bus(1'b0, `REG_STATUS, 8'h00); while (r[bi] !== 1'b1);
  endtask : poll_st
  task automatic wait_tx(input logic v);
    while (tx_line !== v) @(negedge sys_clk_i);
  endtask : wait_tx
  task automatic wait_got(input int n);
    while (dev.got.size() < n) @(negedge sys_clk_i);
  endtask : wait_got
  function automatic int stop_exp(input logic [7:0] t, input logic [7:0] m);
    if (t[7]) return m[3] ? 32 : 16;
    return (m[3] ? 25 : 9) + m[2:0] + ((t[4:3] == 2'b00 && !m[3]) ? 8 : 0);
  endfunction : stop_exp
  initial begin
    int hi;
    int se;
    void'($urandom(3038));
    repeat (4) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    bus(1'b0, `REG_MODE_TWO, 8'h00); `CHK("mode rst", 8'h00, r)
    bus(1'b0, `REG_CTRL, 8'h00); `CHK("ctrl rst", 8'h00, r)
    bus(1'b1, 5'h14, 8'h5A); bus(1'b0, 5'h14, 8'h00); `CHK("unmapped", 8'h00, r)
    bus(1'b0, `REG_TXDATA, 8'h00); `CHK("txdata rd", 8'h00, r)
    for (int k = 0; k < 4; k++) begin
      b = {k[1:0], 6'($urandom)};
      bus(1'b1, `REG_MODE_TWO, b); bus(1'b0, `REG_MODE_TWO, 8'h00); `CHK("mode", b, r)
    end
    // both directions at once in normal mode
    bus(1'b1, `REG_MODE_TWO, 8'h07); bus(1'b1, `REG_CTRL, 8'h1B);
    dev.got.delete(); b = 8'($urandom); c = 8'($urandom);
    fork
      bus(1'b1, `REG_TXDATA, b);
      dev.send(c);
    join
    wait_got(1); `CHK("normal tx", b, dev.got[0])
    poll_st(2); bus(1'b0, `REG_RXDATA, 8'h00); `CHK("normal rx", c, r)
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, `REG_MODE_TWO, ST_MODE[k]); bus(1'b1, `REG_CTRL, ST_CTRL[k]);
      bus(1'b1, `REG_TXDATA, 8'h00); bus(1'b1, `REG_TXDATA, 8'h00);
      wait_tx(1'b0); wait_tx(1'b1);
      hi = 0;
      while (tx_line === 1'b1 && hi < 100) begin @(negedge sys_clk_i); hi++; end
      se = stop_exp(ST_CTRL[k], ST_MODE[k]);
      `CHK("stop len", 1'b1, hi >= se && hi <= se + 2)
      poll_st(1);
    end
    // echo then remote loop, transmitter off
    bus(1'b1, `REG_CTRL, 8'h1A);
    for (int k = 1; k < 4; k += 2) begin
      bus(1'b1, `REG_MODE_TWO, {k[1:0], 6'h07});
      dev.got.delete(); b = 8'($urandom);
      dev.send(b); wait_got(1);
      `CHK("echoed", b, dev.got[0])
      bus(1'b0, `REG_STATUS, 8'h00); `CHK("st", {k != 3, 2'b00}, r[2:0])
      if (k == 1) begin bus(1'b0, `REG_RXDATA, 8'h00); `CHK("echo rx", b, r) end
    end
    bus(1'b1, `REG_CTRL, 8'h1B); bus(1'b1, `REG_MODE_TWO, 8'h87);
    dev.got.delete(); b = 8'($urandom);
    bus(1'b1, `REG_TXDATA, b); poll_st(2);
    bus(1'b0, `REG_RXDATA, 8'h00); `CHK("loop rx", b, r)
    `CHK("loop pin", 0, dev.got.size())
    // fill the buffer while the far end stalls on cts
    bus(1'b1, `REG_MODE_TWO, 8'h17); cts_n <= 1'b1; dev.got.delete(); q.delete();
    for (int k = 0; k < 16; k++) begin
      q.push_back(8'($urandom));
      bus(1'b1, `REG_TXDATA, q[k]);
    end
    bus(1'b0, `REG_STATUS, 8'h00); `CHK("full", 2'b00, r[1:0])
    repeat (300) @(posedge sys_clk_i);
    `CHK("cts hold", 0, dev.got.size())
    cts_n <= 1'b0; wait_tx(1'b0); @(posedge sys_clk_i); cts_n <= 1'b1;
    repeat (400) @(posedge sys_clk_i);
    `CHK("cts mid", 1, dev.got.size())
    cts_n <= 1'b0; wait_got(16);
    for (int k = 0; k < 16; k++) `CHK("drain", q[k], dev.got[k])
    poll_st(1);
    // line turnaround with automatic rts release
    bus(1'b1, `REG_MODE_TWO, 8'h27); bus(1'b1, `REG_CTRL, 8'h1F);
    bus(1'b0, `REG_STATUS, 8'h00); `CHK("rts on", 1'b0, rts_n)
    dev.got.delete(); b = 8'($urandom);
    bus(1'b1, `REG_TXDATA, b); bus(1'b1, `REG_CTRL, 8'h1E);
    while (rts_n !== 1'b1) @(negedge sys_clk_i);
    `CHK("rts after", 1, dev.got.size())
    bus(1'b0, `REG_CTRL, 8'h00); `CHK("rts bit", 1'b0, r[2])
    end_sim();
  end
endmodule : uart_channel_mode_flow_ctrl_tb
